/* File: hw/txmc_pkg.sv */
// Purpose: Shared constants for the transmit modulation configuration block
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes:   Offsets are register indices; byte address is four times the index
package txmc_pkg;
	localparam logic [7:0]  TXMC_IDX_RATE_HIGH   = 8'h6e;
	localparam logic [7:0]  TXMC_IDX_RATE_LOW    = 8'h6f;
	localparam logic [7:0]  TXMC_IDX_MOD_ONE     = 8'h70;
	localparam logic [7:0]  TXMC_IDX_MOD_TWO     = 8'h71;
	localparam logic [7:0]  TXMC_IDX_DEV_LOW     = 8'h72;
	localparam logic [7:0]  TXMC_IDX_OFS_LOW     = 8'h73;
	localparam logic [7:0]  TXMC_IDX_OFS_HIGH    = 8'h74;
	localparam logic [7:0]  TXMC_IDX_AFC_LOW     = 8'h80;
	localparam logic [7:0]  TXMC_IDX_AFC_HIGH    = 8'h81;
	localparam logic [7:0]  TXMC_RST_RATE_HIGH   = 8'h0a;
	localparam logic [7:0]  TXMC_RST_RATE_LOW    = 8'h3d;
	localparam logic [7:0]  TXMC_RST_MOD_ONE     = 8'h00;
	localparam logic [7:0]  TXMC_RST_MOD_TWO     = 8'h00;
	localparam logic [7:0]  TXMC_RST_DEV_LOW     = 8'h20;
	localparam logic [7:0]  TXMC_RST_OFS_LOW     = 8'h00;
	localparam logic [1:0]  TXMC_RST_OFS_HIGH    = 2'h0;
	localparam logic [7:0]  TXMC_MOD_ONE_MASK    = 8'h3f;
	localparam logic [7:0]  TXMC_OFS_HIGH_MASK   = 8'h03;
	localparam int          TXMC_B1_SCALE        = 5;
	localparam int          TXMC_B1_PH_PWDN      = 4;
	localparam int          TXMC_B1_MAN_PPOL     = 3;
	localparam int          TXMC_B1_MAN_INV      = 2;
	localparam int          TXMC_B1_MAN_EN       = 1;
	localparam int          TXMC_B1_WHITE        = 0;
	localparam int          TXMC_B2_CLK_HI       = 7;
	localparam int          TXMC_B2_CLK_LO       = 6;
	localparam int          TXMC_B2_SRC_HI       = 5;
	localparam int          TXMC_B2_SRC_LO       = 4;
	localparam int          TXMC_B2_INV          = 3;
	localparam int          TXMC_B2_DEV_MSB      = 2;
	localparam int          TXMC_B2_TYP_HI       = 1;
	localparam int          TXMC_B2_TYP_LO       = 0;
	localparam int          TXMC_RATE_ACC_W      = 32;
	localparam logic [31:0] TXMC_RATE_NUM        = 32'h0000_03e8;
	localparam int          TXMC_RATE_SHIFT_NORM = 16;
	localparam int          TXMC_RATE_SHIFT_SCLD = 21;
	localparam int          TXMC_CLOCK_KHZ       = 10000;
	localparam logic [8:0]  TXMC_PN9_SEED        = 9'h1ff;
	localparam logic [1:0]  TXMC_CLK_NONE        = 2'h0;
	localparam logic [1:0]  TXMC_CLK_GPIO        = 2'h1;
	localparam logic [1:0]  TXMC_CLK_SDO         = 2'h2;
	localparam logic [1:0]  TXMC_CLK_IRQ         = 2'h3;
	localparam logic [1:0]  TXMC_SRC_GPIO        = 2'h0;
	localparam logic [1:0]  TXMC_SRC_SDI         = 2'h1;
	localparam logic [1:0]  TXMC_SRC_FIFO        = 2'h2;
	localparam logic [1:0]  TXMC_SRC_PN9         = 2'h3;
	localparam logic [1:0]  TXMC_HTRANS_NONSEQ   = 2'h2;
	localparam int          TXMC_PREAMBLE_BITS   = 8;
endpackage : txmc_pkg

/* File: hw/txmc_pn9.sv */
// Purpose: PN9 and whitening sequence source
// Assumes: Advances one step per enable pulse
// Notes:   Polynomial x^9 + x^5 + 1
`timescale 1ns/1ps
`default_nettype none
module txmc_pn9
	import txmc_pkg::*;
(
	input  wire logic i_clock,
	input  wire logic i_rstn,
	input  wire logic i_restart,
	input  wire logic i_step,
	output logic      o_bit
);
	logic [8:0] lfsr_q;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn)
			lfsr_q <= TXMC_PN9_SEED;
		else if (i_restart)
			lfsr_q <= TXMC_PN9_SEED;
		else if (i_step)
			lfsr_q <= {lfsr_q[0] ^ lfsr_q[5], lfsr_q[8:1]};
	end

	assign o_bit = lfsr_q[0];
endmodule : txmc_pn9
`default_nettype wire

/* File: hw/txmc_rate_gen.sv */
// Purpose: Bit-rate enable generator from the 16-bit rate word
// Assumes: 10 MHz clock; rate below clock rate
// Notes:   Phase accumulator: rate_kbps/clock_khz = word*1000/2^shift/10000
`timescale 1ns/1ps
`default_nettype none
module txmc_rate_gen
	import txmc_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_rstn,
	input  wire logic [15:0] i_rate_word,
	input  wire logic        i_scale,
	output logic             o_bit_tick
);
	// Increment per clock = word*1000/10000 scaled to 2^32 accumulator
	logic [TXMC_RATE_ACC_W-1:0] acc_q;
	logic [TXMC_RATE_ACC_W:0]   sum_d;
	logic [47:0]                inc_full;
	logic [TXMC_RATE_ACC_W-1:0] inc;

	always_comb begin
		inc_full = ({32'h0000_0000, i_rate_word} * 48'(TXMC_RATE_NUM))
			/ 48'(TXMC_CLOCK_KHZ);
		if (i_scale)
			inc = TXMC_RATE_ACC_W'(inc_full << (TXMC_RATE_ACC_W - TXMC_RATE_SHIFT_SCLD));
		else
			inc = TXMC_RATE_ACC_W'(inc_full << (TXMC_RATE_ACC_W - TXMC_RATE_SHIFT_NORM));
		sum_d = {1'b0, acc_q} + {1'b0, inc};
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn)
			acc_q <= '0;
		else
			acc_q <= sum_d[TXMC_RATE_ACC_W-1:0];
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn)
			o_bit_tick <= 1'b0;
		else
			o_bit_tick <= sum_d[TXMC_RATE_ACC_W];
	end
endmodule : txmc_rate_gen
`default_nettype wire

/* File: hw/txmc_top.sv */
// Purpose: Transmit modulation configuration registers and bit path
// Assumes: AHB-Lite slave, single word transfers, zero wait states on writes, one on reads
// Notes:   Offset low read returns AFC result, not written value
`timescale 1ns/1ps
`default_nettype none
module txmc_top
	import txmc_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_rstn,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic [31:0]      o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	input  wire logic        i_low_power,
	input  wire logic        i_tx_active,
	input  wire logic [9:0]  i_afc_result,
	input  wire logic        i_gpio_data,
	input  wire logic        i_sdi_data,
	input  wire logic        i_chip_select_n,
	input  wire logic        i_fifo_valid,
	input  wire logic        i_fifo_data,
	input  wire logic        i_rx_data,
	output logic             o_fifo_take,
	output logic             o_tx_bit,
	output logic             o_rx_bit,
	output logic             o_gpio_clock,
	output logic             o_sdo_clock,
	output logic             o_interrupt_request_pin_clock,
	output logic             o_packet_handler_pwdn,
	output logic [1:0]       o_modulation_type,
	output logic [8:0]       o_deviation_value,
	output logic [9:0]       o_carrier_offset_value,
	output logic [15:0]      o_rate_word,
	output logic             o_rate_scale
);
	typedef enum logic [1:0] {TXMC_ST_IDLE, TXMC_ST_PREAMBLE, TXMC_ST_DATA} txmc_state_e;

	logic [7:0]  rate_high_q;
	logic [7:0]  rate_low_q;
	logic [7:0]  mod_one_q;
	logic [7:0]  mod_two_q;
	logic [7:0]  dev_low_q;
	logic [7:0]  ofs_low_q;
	logic [1:0]  ofs_high_q;
	logic        wr_pend_q;
	logic [7:0]  wr_idx_q;
	logic        rd_pend_q;
	logic [7:0]  rd_idx_q;
	txmc_state_e state_q;
	logic [3:0]  pre_cnt_q;
	logic        half_q;
	logic        cur_bit_q;
	logic        bit_tick;
	logic        white_bit;
	logic        src_bit;
	logic        coded_bit;
	logic        addr_phase;
	logic [7:0]  rd_byte;

	function automatic logic [7:0] word_index(input logic [31:0] addr);
		word_index = addr[9:2];
	endfunction

	function automatic logic [7:0] read_mux(input logic [7:0] idx, input logic [7:0] rh,
			input logic [7:0] rl, input logic [7:0] m1, input logic [7:0] m2,
			input logic [7:0] dl, input logic [9:0] afc);
		case (idx)
			TXMC_IDX_RATE_HIGH: read_mux = rh;
			TXMC_IDX_RATE_LOW:  read_mux = rl;
			TXMC_IDX_MOD_ONE:   read_mux = m1 & TXMC_MOD_ONE_MASK;
			TXMC_IDX_MOD_TWO:   read_mux = m2;
			TXMC_IDX_DEV_LOW:   read_mux = dl;
			TXMC_IDX_OFS_LOW:   read_mux = afc[7:0];
			TXMC_IDX_OFS_HIGH:  read_mux = {6'h00, afc[9:8]};
			default:            read_mux = 8'h00;
		endcase
	endfunction

	assign addr_phase = i_hsel && i_hready && (i_htrans == TXMC_HTRANS_NONSEQ);

	// Bus capture; NONSEQ address phase accepted when hsel and hready are high
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			wr_idx_q  <= 8'h00;
			rd_idx_q  <= 8'h00;
		end else begin
			wr_pend_q <= addr_phase && i_hwrite;
			rd_pend_q <= addr_phase && !i_hwrite;
			if (addr_phase) begin
				wr_idx_q <= word_index(i_haddr);
				rd_idx_q <= word_index(i_haddr);
			end
		end
	end

	// Read data registered so hrdata comes from a flop; one extra wait
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_hrdata    <= 32'h0000_0000;
			o_hreadyout <= 1'b1;
		end else begin
			if (addr_phase && !i_hwrite)
				o_hreadyout <= 1'b0;
			else
				o_hreadyout <= 1'b1;
			if (rd_pend_q)
				o_hrdata <= {24'h00_0000, rd_byte};
		end
	end

	assign rd_byte = read_mux(rd_idx_q, rate_high_q, rate_low_q, mod_one_q,
		mod_two_q, dev_low_q, i_afc_result);

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn)
			o_hresp <= 1'b0;
		else
			o_hresp <= 1'b0;
	end

	// Register writes in data phase
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			rate_high_q <= TXMC_RST_RATE_HIGH;
			rate_low_q  <= TXMC_RST_RATE_LOW;
			mod_one_q   <= TXMC_RST_MOD_ONE;
			mod_two_q   <= TXMC_RST_MOD_TWO;
			dev_low_q   <= TXMC_RST_DEV_LOW;
			ofs_low_q   <= TXMC_RST_OFS_LOW;
			ofs_high_q  <= TXMC_RST_OFS_HIGH;
		end else if (wr_pend_q) begin
			case (wr_idx_q)
				TXMC_IDX_RATE_HIGH: rate_high_q <= i_hwdata[7:0];
				TXMC_IDX_RATE_LOW:  rate_low_q  <= i_hwdata[7:0];
				TXMC_IDX_MOD_ONE:   mod_one_q   <= i_hwdata[7:0] & TXMC_MOD_ONE_MASK;
				TXMC_IDX_MOD_TWO:   mod_two_q   <= i_hwdata[7:0];
				TXMC_IDX_DEV_LOW:   dev_low_q   <= i_hwdata[7:0];
				TXMC_IDX_OFS_LOW:   ofs_low_q   <= i_hwdata[7:0];
				TXMC_IDX_OFS_HIGH:  ofs_high_q  <= i_hwdata[1:0];
				default:            ;
			endcase
		end
	end

	// Configuration outputs, each from a flop
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rate_word            <= {TXMC_RST_RATE_HIGH, TXMC_RST_RATE_LOW};
			o_rate_scale           <= 1'b0;
			o_modulation_type      <= 2'h0;
			o_deviation_value      <= {1'b0, TXMC_RST_DEV_LOW};
			o_carrier_offset_value <= {TXMC_RST_OFS_HIGH, TXMC_RST_OFS_LOW};
			o_packet_handler_pwdn  <= 1'b0;
		end else begin
			o_rate_word            <= {rate_high_q, rate_low_q};
			o_rate_scale           <= mod_one_q[TXMC_B1_SCALE];
			o_modulation_type      <= mod_two_q[TXMC_B2_TYP_HI:TXMC_B2_TYP_LO];
			o_deviation_value      <= {mod_two_q[TXMC_B2_DEV_MSB], dev_low_q};
			o_carrier_offset_value <= {ofs_high_q, ofs_low_q};
			o_packet_handler_pwdn  <= mod_one_q[TXMC_B1_PH_PWDN] && i_low_power;
		end
	end

	// Manchester halves need two ticks per bit
	txmc_rate_gen i_txmc_rate_gen (
		.i_clock     (i_clock),
		.i_rstn      (i_rstn),
		.i_rate_word ({rate_high_q, rate_low_q}),
		.i_scale     (mod_one_q[TXMC_B1_SCALE]),
		.o_bit_tick  (bit_tick)
	);

	logic bit_step;
	assign bit_step = bit_tick && (!mod_one_q[TXMC_B1_MAN_EN] || half_q);

	txmc_pn9 i_txmc_pn9 (
		.i_clock   (i_clock),
		.i_rstn    (i_rstn),
		.i_restart (!i_tx_active),
		.i_step    (bit_step && state_q == TXMC_ST_DATA),
		.o_bit     (white_bit)
	);

	always_comb begin
		case (mod_two_q[TXMC_B2_SRC_HI:TXMC_B2_SRC_LO])
			TXMC_SRC_GPIO: src_bit = i_gpio_data;
			TXMC_SRC_SDI:  src_bit = i_chip_select_n ? i_sdi_data : 1'b0;
			TXMC_SRC_FIFO: src_bit = i_fifo_valid ? i_fifo_data : 1'b0;
			TXMC_SRC_PN9:  src_bit = white_bit;
			default:       src_bit = 1'b0;
		endcase
	end

	// Whitening applies to non-PN9 sources only
	always_comb begin
		coded_bit = src_bit;
		if (mod_one_q[TXMC_B1_WHITE] && mod_two_q[TXMC_B2_SRC_HI:TXMC_B2_SRC_LO] != TXMC_SRC_PN9)
			coded_bit = src_bit ^ white_bit;
	end

	// Preamble only emitted with Manchester on
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q   <= TXMC_ST_IDLE;
			pre_cnt_q <= 4'h0;
			half_q    <= 1'b0;
			cur_bit_q <= 1'b0;
		end else begin
			case (state_q)
				TXMC_ST_IDLE: begin
					half_q    <= 1'b0;
					pre_cnt_q <= 4'h0;
					if (i_tx_active)
						state_q <= mod_one_q[TXMC_B1_MAN_EN] ? TXMC_ST_PREAMBLE : TXMC_ST_DATA;
				end
				TXMC_ST_PREAMBLE: begin
					if (!i_tx_active)
						state_q <= TXMC_ST_IDLE;
					else if (bit_tick) begin
						half_q <= !half_q;
						cur_bit_q <= mod_one_q[TXMC_B1_MAN_PPOL];
						if (half_q) begin
							pre_cnt_q <= pre_cnt_q + 4'h1;
							if (pre_cnt_q == 4'(TXMC_PREAMBLE_BITS - 1))
								state_q <= TXMC_ST_DATA;
						end
					end
				end
				TXMC_ST_DATA: begin
					if (!i_tx_active)
						state_q <= TXMC_ST_IDLE;
					else if (bit_tick) begin
						half_q <= mod_one_q[TXMC_B1_MAN_EN] ? !half_q : 1'b0;
						if (!half_q || !mod_one_q[TXMC_B1_MAN_EN])
							cur_bit_q <= coded_bit ^ mod_one_q[TXMC_B1_MAN_INV];
					end
				end
				default: state_q <= TXMC_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn)
			o_fifo_take <= 1'b0;
		else
			o_fifo_take <= bit_step && state_q == TXMC_ST_DATA
				&& mod_two_q[TXMC_B2_SRC_HI:TXMC_B2_SRC_LO] == TXMC_SRC_FIFO;
	end

	// Manchester: first half carries bit, second its complement
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_tx_bit <= 1'b0;
			o_rx_bit <= 1'b0;
		end else begin
			o_tx_bit <= (mod_one_q[TXMC_B1_MAN_EN] && !half_q ? !cur_bit_q : cur_bit_q)
				^ mod_two_q[TXMC_B2_INV];
			o_rx_bit <= i_rx_data ^ mod_two_q[TXMC_B2_INV];
		end
	end

	// Data clock routing; code 00 gives no clock
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_gpio_clock                  <= 1'b0;
			o_sdo_clock                   <= 1'b0;
			o_interrupt_request_pin_clock <= 1'b0;
		end else begin
			o_gpio_clock <= bit_step && mod_two_q[TXMC_B2_CLK_HI:TXMC_B2_CLK_LO] == TXMC_CLK_GPIO;
			o_sdo_clock  <= bit_step && mod_two_q[TXMC_B2_CLK_HI:TXMC_B2_CLK_LO] == TXMC_CLK_SDO;
			o_interrupt_request_pin_clock <= bit_step
				&& mod_two_q[TXMC_B2_CLK_HI:TXMC_B2_CLK_LO] == TXMC_CLK_IRQ;
		end
	end
endmodule : txmc_top
`default_nettype wire

/* File: verif/test_tx_modulation_config.sv */
// Purpose: Self-checking bench for txmc_top
// Assumes: Zero or one wait state slave, 10 MHz clock
// Notes:   Host stays above 30 kbps and uses FSK, no data clock need
`timescale 1ns/1ps
`default_nettype none
module test_tx_modulation_config;
	import txmc_pkg::*;
	logic        clock, rstn, hsel, hwrite, hready, hresp, low_power, tx_active, rx_data;
	logic        stall, gpio_d, sdi_d, csn, fvalid, fdata, ftake, tx_bit, rx_bit;
	logic        gclk, sclk, iclk, pwdn, scale;
	logic [1:0]  htrans, mtype;
	logic [31:0] haddr, hwdata, hrdata;
	logic [9:0]  afc, ofs;
	logic [8:0]  dev;
	logic [15:0] rate;
	int          errors, n_checks;

	txmc_top i_txmc_top (.i_clock(clock), .i_rstn(rstn), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.i_low_power(low_power), .i_tx_active(tx_active), .i_afc_result(afc),
		.i_gpio_data(gpio_d), .i_sdi_data(sdi_d), .i_chip_select_n(csn),
		.i_fifo_valid(fvalid), .i_fifo_data(fdata), .i_rx_data(rx_data),
		.o_fifo_take(ftake), .o_tx_bit(tx_bit), .o_rx_bit(rx_bit), .o_gpio_clock(gclk),
		.o_sdo_clock(sclk), .o_interrupt_request_pin_clock(iclk),
		.o_packet_handler_pwdn(pwdn), .o_modulation_type(mtype),
		.o_deviation_value(dev), .o_carrier_offset_value(ofs), .o_rate_word(rate),
		.o_rate_scale(scale));
	txmc_host_model i_txmc_host_model (.i_clock(clock), .i_rstn(rstn), .i_stall(stall),
		.i_fifo_take(ftake), .o_gpio_data(gpio_d), .o_sdi_data(sdi_d),
		.o_chip_select_n(csn), .o_fifo_valid(fvalid), .o_fifo_data(fdata));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Address held until ready sampled high, then data phase likewise
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
			output logic [7:0] rd);
		@(posedge clock);
		hsel   <= 1'b1;
		htrans <= TXMC_HTRANS_NONSEQ;
		haddr  <= {22'h00_0000, idx, 2'h0};
		hwrite <= wr;
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, wd};
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		rd = hrdata[7:0];
	endtask : bus

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] x;
		bus(1'b1, idx, d, x);
	endtask : wr

	task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
		logic [7:0] x;
		bus(1'b0, idx, 8'h00, x);
		chk({24'h00_0000, x}, {24'h00_0000, e});
	endtask : rdc

	task automatic t_reset;
		rdc(TXMC_IDX_RATE_HIGH, 8'h0a);
		rdc(TXMC_IDX_RATE_LOW, 8'h3d);
		rdc(TXMC_IDX_MOD_ONE, 8'h00);
		rdc(TXMC_IDX_MOD_TWO, 8'h00);
		rdc(TXMC_IDX_DEV_LOW, 8'h20);
		rdc(TXMC_IDX_OFS_LOW, 8'ha5);
		rdc(TXMC_IDX_OFS_HIGH, 8'h02);
		chk(rate, 32'h0000_0a3d);
		chk(dev, 32'h0000_0020);
		chk(ofs, 32'h0000_0000);
		wr(8'h40, 8'hff);
		rdc(8'h40, 8'h00);
	endtask : t_reset

	task automatic t_write;
		wr(TXMC_IDX_RATE_HIGH, 8'hff);
		wr(TXMC_IDX_RATE_LOW, 8'h12);
		wr(TXMC_IDX_MOD_ONE, 8'hff);
		wr(TXMC_IDX_MOD_TWO, 8'h06);
		wr(TXMC_IDX_DEV_LOW, 8'h55);
		wr(TXMC_IDX_OFS_LOW, 8'h81);
		wr(TXMC_IDX_OFS_HIGH, 8'h03);
		repeat (3) @(posedge clock);
		chk(rate, 32'h0000_ff12);
		chk(scale, 32'h0000_0001);
		chk(dev, 32'h0000_0155);
		chk(ofs, 32'h0000_0381);
		rdc(TXMC_IDX_MOD_ONE, 8'h3f);
		rdc(TXMC_IDX_DEV_LOW, 8'h55);
		rdc(TXMC_IDX_OFS_LOW, 8'ha5);
		for (int t = 0; t < 4; t++) begin
			wr(TXMC_IDX_MOD_TWO, 8'h40 | 8'(t));
			repeat (3) @(posedge clock);
			chk(mtype, 32'(t));
		end
	endtask : t_write

	task automatic t_invert;
		wr(TXMC_IDX_MOD_TWO, 8'h0a);
		rx_data <= 1'b1;
		repeat (3) @(posedge clock);
		chk(rx_bit, 32'h0000_0000);
		rx_data <= 1'b0;
		repeat (3) @(posedge clock);
		chk(rx_bit, 32'h0000_0001);
		wr(TXMC_IDX_MOD_TWO, 8'h02);
		repeat (3) @(posedge clock);
		chk(rx_bit, 32'h0000_0000);
	endtask : t_invert

	task automatic t_pwdn;
		wr(TXMC_IDX_MOD_ONE, 8'h10);
		low_power <= 1'b1;
		repeat (3) @(posedge clock);
		chk(pwdn, 32'h0000_0001);
		wr(TXMC_IDX_MOD_ONE, 8'h00);
		repeat (4) @(posedge clock);
		chk(pwdn, 32'h0000_0000);
		low_power <= 1'b0;
	endtask : t_pwdn

	// Word 0xFFFF scaled: 31.25 kbps, 320 clocks a bit, ten bits a window
	task automatic t_routing;
		int         k[5];
		logic       last;
		wr(TXMC_IDX_MOD_ONE, 8'h20);
		wr(TXMC_IDX_RATE_HIGH, 8'hff);
		wr(TXMC_IDX_RATE_LOW, 8'hff);
		for (int c = 0; c < 4; c++) begin
			wr(TXMC_IDX_MOD_TWO, {2'(c), 2'(c), 4'h2});
			repeat (4) @(posedge clock);
			k = '{0, 0, 0, 0, 0};
			last = tx_bit;
			repeat (3200) begin
				@(posedge clock);
				k[0] += int'(gclk);
				k[1] += int'(sclk);
				k[2] += int'(iclk);
				k[3] += int'(ftake);
				k[4] += int'(tx_bit !== last);
				last = tx_bit;
			end
			for (int j = 0; j < 4; j++) begin
				chk((k[j] >= 9 && k[j] <= 11) ? 10 : k[j], ((j < 3) ? (c == j + 1) : (c == 2)) ? 10 : 0);
			end
			if (c == 3) chk(k[4] != 0, 32'h0000_0001);
		end
	endtask : t_routing

	// Ones preamble, then inverted PN9 ones; bit value sampled at clock pulse
	task automatic t_manch;
		int         n;
		logic       e;
		wr(TXMC_IDX_MOD_TWO, 8'h72);
		wr(TXMC_IDX_MOD_ONE, 8'h2e);
		tx_active <= 1'b0;
		repeat (3) @(posedge clock);
		tx_active <= 1'b1;
		n = 0;
		while (n < 12) begin
			@(posedge clock);
			if (gclk) begin
				e = (n < 8);
				chk(tx_bit, e);
				@(posedge clock);
				chk(tx_bit, !e);
				n++;
			end
		end
	endtask : t_manch

	initial begin
		repeat (40000) @(posedge clock);
		errors++;
		give_verdict();
	end

	initial begin
		errors = 0;
		n_checks = 0;
		rstn <= 1'b0;
		hsel <= 1'b0;
		haddr <= 32'h0000_0000;
		htrans <= 2'h0;
		hwrite <= 1'b0;
		hwdata <= 32'h0000_0000;
		low_power <= 1'b0;
		tx_active <= 1'b0;
		afc <= 10'h2a5;
		rx_data <= 1'b0;
		stall <= 1'b0;
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		tx_active <= 1'b1;
		t_reset();
		t_write();
		t_invert();
		t_pwdn();
		t_routing();
		t_manch();
		give_verdict();
	end
endmodule : test_tx_modulation_config
`default_nettype wire

/* File: verif/txmc_host_model.sv */
// Purpose: Host side data feeder for the transmit bit path
// Assumes: Levels change only at clock edges
// Notes:   Stall drops FIFO valid; data then shows the inverse
`timescale 1ns/1ps
`default_nettype none
module txmc_host_model (
	input  wire logic i_clock,
	input  wire logic i_rstn,
	input  wire logic i_stall,
	input  wire logic i_fifo_take,
	output logic      o_gpio_data,
	output logic      o_sdi_data,
	output logic      o_chip_select_n,
	output logic      o_fifo_valid,
	output logic      o_fifo_data
);
	logic [7:0] pat_q;
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			pat_q <= 8'hb4;
		end else if (i_fifo_take) begin
			pat_q <= {pat_q[6:0], pat_q[7]};
		end
	end
	// Deselected so serial input may carry direct data
	assign o_chip_select_n = 1'b1;
	assign o_sdi_data      = pat_q[0];
	assign o_gpio_data     = pat_q[3];
	assign o_fifo_valid    = !i_stall;
	assign o_fifo_data     = i_stall ? ~pat_q[7] : pat_q[7];
endmodule : txmc_host_model
`default_nettype wire

/* File: verif/txmc_top_sva.sv */
// Purpose: Port-level checks for txmc_top
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to every txmc_top instance after the module
`timescale 1ns/1ps
`default_nettype none
module txmc_top_chk
	import txmc_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_rstn,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic        i_hready,
	input  wire logic [31:0] o_hrdata,
	input  wire logic        o_hreadyout,
	input  wire logic        o_hresp,
	input  wire logic        i_low_power,
	input  wire logic [9:0]  i_afc_result,
	input  wire logic        o_packet_handler_pwdn,
	input  wire logic        o_gpio_clock,
	input  wire logic        o_sdo_clock,
	input  wire logic        o_interrupt_request_pin_clock,
	input  wire logic [8:0]  o_deviation_value,
	input  wire logic [15:0] o_rate_word
);
	logic taken;
	logic wr_acc;
	logic rd_acc;
	assign taken  = i_hsel && i_hready && (i_htrans == TXMC_HTRANS_NONSEQ);
	assign wr_acc = taken && i_hwrite;
	assign rd_acc = taken && !i_hwrite;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);

	property p_okay; o_hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("error response seen");
	property p_rd_wait; rd_acc |=> !o_hreadyout ##1 o_hreadyout; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	property p_wr_nowait; wr_acc |=> o_hreadyout; endproperty
	a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
	property p_upper; $rose(o_hreadyout) |-> o_hrdata[31:8] == 24'h00_0000; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_afc; rd_acc && (i_haddr[9:2] == TXMC_IDX_OFS_LOW)
		|-> ##2 o_hrdata[7:0] == i_afc_result[7:0]; endproperty
	a_afc: assert property (p_afc) else $error("offset read not correction");
	property p_pwdn; !i_low_power |=> !o_packet_handler_pwdn; endproperty
	a_pwdn: assert property (p_pwdn) else $error("power down outside low power");
	property p_route; $onehot0({o_gpio_clock, o_sdo_clock, o_interrupt_request_pin_clock});
	endproperty
	a_route: assert property (p_route) else $error("clock on two pins");
	property p_dev; $changed(o_deviation_value) |-> $past(wr_acc, 2) || $past(wr_acc, 3);
	endproperty
	a_dev: assert property (p_dev) else $error("deviation moved unwritten");
	property p_rate; $changed(o_rate_word) |-> $past(wr_acc, 2) || $past(wr_acc, 3);
	endproperty
	a_rate: assert property (p_rate) else $error("rate moved unwritten");
endmodule : txmc_top_chk
bind txmc_top txmc_top_chk i_txmc_top_chk (.*);
`default_nettype wire
